// file: src/bpcs_pkg.sv
// package for the bridge primary command and status registers
package bpcs_pkg;
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam logic [7:0] STS_OFFSET = 8'h06;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] STS_RESET = 16'h0210;
    // writable command bits: 9, 8, 6, 5, 2, 1, 0
    localparam logic [15:0] CMD_WMASK = 16'h0367;
    localparam int CMD_IO_BIT = 0;
    localparam int CMD_MEM_BIT = 1;
    localparam int CMD_MASTER_BIT = 2;
    localparam int CMD_VGA_BIT = 5;
    localparam int CMD_PARITY_BIT = 6;
    localparam int CMD_SERR_BIT = 8;
    localparam int CMD_FB2B_BIT = 9;
    localparam int STS_DPE_BIT = 8;
    localparam int STS_STA_BIT = 11;
    localparam int STS_RTA_BIT = 12;
    localparam int STS_RMA_BIT = 13;
    localparam int STS_SSE_BIT = 14;
    localparam int STS_PE_BIT = 15;
    // fixed status bits: devsel timing 01b at 10:9, capability list at 4
    localparam logic [15:0] STS_FIXED = 16'h0210;
    localparam logic [9:0] VGA_ADDR_A = 10'h3c6;
    localparam logic [9:0] VGA_ADDR_B = 10'h3c8;
    localparam logic [9:0] VGA_ADDR_C = 10'h3c9;

    typedef struct packed {
        logic parity_error;
        logic serr_signal;
        logic master_abort_rx;
        logic target_abort_rx;
        logic target_abort_tx;
        logic parity_pin;
        logic bus_master_phase;
    } bpcs_event_type;
endpackage

// file: src/bpcs_regs.sv
// primary command and status registers of the bridge
`timescale 1ns/1ns
`default_nettype none
module bpcs_regs (
    input wire logic clock_i,                      // primary bus clock
    input wire logic arst_n_i,                     // async reset, active low
    input wire logic cfg_write_i,                  // config write strobe
    input wire logic cfg_read_i,                   // config read strobe
    input wire logic [7:0] cfg_addr_i,             // config byte offset
    input wire logic [3:0] cfg_be_i,               // byte enables of the dword
    input wire logic [31:0] cfg_wdata_i,           // write data
    output logic [31:0] cfg_rdata_o,               // read data, registered
    input wire bpcs_pkg::bpcs_event_type events_i, // one-cycle event pulses
    input wire logic serr_request_i,               // core wants to signal system error
    input wire logic io_write_i,                   // primary I/O write decode request
    input wire logic [9:0] io_addr_i,              // primary I/O address bits 9..0
    output logic serr_n_o,                         // system-error pin output value
    output logic serr_oe_n_o,                      // system-error pin enable, low drives
    output logic parity_resp_en_o,                 // parity error response enabled
    output logic mem_fwd_en_o,                     // forward primary memory accesses
    output logic io_fwd_en_o,                      // forward primary I/O accesses
    output logic master_en_o,                      // may master on primary bus
    output logic secondary_resp_en_o,              // may respond on secondary bus
    output logic vga_fwd_o                         // forward this I/O write as palette snoop
);
    logic [15:0] command;
    logic [15:0] next_command;
    logic [15:0] status_flags;
    logic [15:0] next_status_flags;
    logic [31:0] next_cfg_rdata;
    logic [15:0] set_bits;
    logic [15:0] clr_bits;
    logic dword_hit;

    assign dword_hit = (cfg_addr_i[7:2] == bpcs_pkg::CMD_OFFSET[7:2]);

    always_comb
    begin
        next_command = command;
        if (cfg_write_i && dword_hit)
        begin
            if (cfg_be_i[0])
                next_command[7:0] = cfg_wdata_i[7:0] & bpcs_pkg::CMD_WMASK[7:0];
            if (cfg_be_i[1])
                next_command[15:8] = cfg_wdata_i[15:8] & bpcs_pkg::CMD_WMASK[15:8];
        end
    end

    always_comb
    begin
        set_bits = 16'h0000;
        clr_bits = 16'h0000;
        set_bits[bpcs_pkg::STS_PE_BIT] = events_i.parity_error;
        set_bits[bpcs_pkg::STS_SSE_BIT] = events_i.serr_signal
            & command[bpcs_pkg::CMD_SERR_BIT];
        set_bits[bpcs_pkg::STS_RMA_BIT] = events_i.master_abort_rx;
        set_bits[bpcs_pkg::STS_RTA_BIT] = events_i.target_abort_rx;
        set_bits[bpcs_pkg::STS_STA_BIT] = events_i.target_abort_tx;
        set_bits[bpcs_pkg::STS_DPE_BIT] = events_i.parity_pin & events_i.bus_master_phase
            & command[bpcs_pkg::CMD_PARITY_BIT];
        if (cfg_write_i && dword_hit)
        begin
            if (cfg_be_i[2])
                clr_bits[7:0] = cfg_wdata_i[23:16];
            if (cfg_be_i[3])
                clr_bits[15:8] = cfg_wdata_i[31:24];
        end
        // a new event wins over a clear in the same cycle
        next_status_flags = ((status_flags & ~clr_bits) | set_bits) & ~bpcs_pkg::STS_FIXED;
    end

    always_comb
    begin
        next_cfg_rdata = 32'h0000_0000;
        if (cfg_read_i && dword_hit)
            next_cfg_rdata = {status_flags | bpcs_pkg::STS_FIXED, command};
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            command <= bpcs_pkg::CMD_RESET;
            status_flags <= bpcs_pkg::STS_RESET & ~bpcs_pkg::STS_FIXED;
            cfg_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            command <= next_command;
            status_flags <= next_status_flags;
            cfg_rdata_o <= next_cfg_rdata;
        end
    end

    assign serr_n_o = 1'b0;
    assign serr_oe_n_o = ~(command[bpcs_pkg::CMD_SERR_BIT] & serr_request_i);
    assign parity_resp_en_o = command[bpcs_pkg::CMD_PARITY_BIT];
    assign mem_fwd_en_o = command[bpcs_pkg::CMD_MEM_BIT];
    assign io_fwd_en_o = command[bpcs_pkg::CMD_IO_BIT];
    assign master_en_o = command[bpcs_pkg::CMD_MASTER_BIT];
    assign secondary_resp_en_o = command[bpcs_pkg::CMD_MASTER_BIT];
    assign vga_fwd_o = command[bpcs_pkg::CMD_VGA_BIT] & io_write_i
        & ((io_addr_i == bpcs_pkg::VGA_ADDR_A) || (io_addr_i == bpcs_pkg::VGA_ADDR_B)
        || (io_addr_i == bpcs_pkg::VGA_ADDR_C));
endmodule // bpcs_regs
`default_nettype wire

// file: bench/bpcs_properties.sv
// checker for the command and status registers
`timescale 1ns/1ns
`default_nettype none
module bpcs_chk (
    input wire logic clock_i, // clock
    input wire logic arst_n_i, // reset
    input wire logic cfg_write_i, // write
    input wire logic cfg_read_i, // read
    input wire logic [7:0] cfg_addr_i, // offset
    input wire logic [31:0] cfg_rdata_o, // rdata
    input wire bpcs_pkg::bpcs_event_type events_i, // events
    input wire logic serr_request_i, // serr ask
    input wire logic serr_oe_n_o, // serr oe
    input wire logic parity_resp_en_o, // parity
    input wire logic mem_fwd_en_o, // mem
    input wire logic io_fwd_en_o, // io
    input wire logic master_en_o, // master
    input wire logic secondary_resp_en_o // sec
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    wire logic hit = cfg_read_i && cfg_addr_i[7:2] == 6'h01;
    chk_serr_quiet: assert property (!serr_request_i |-> serr_oe_n_o) else $error("serr");
    chk_fixed_bits: assert property (hit |=> (cfg_rdata_o & 32'h0600_fc98) == 32'h0200_0000) else $error("fix");
    chk_sec_follow: assert property (secondary_resp_en_o == master_en_o) else $error("sec");
    chk_mem_hold: assert property (!$past(cfg_write_i) |-> $stable(mem_fwd_en_o)) else $error("mem");
    chk_io_hold: assert property (!$past(cfg_write_i) |-> $stable(io_fwd_en_o)) else $error("io");
    chk_par_hold: assert property (!$past(cfg_write_i) |-> $stable(parity_resp_en_o)) else $error("par");
    chk_abort_set: assert property (events_i.master_abort_rx ##1 hit |=> cfg_rdata_o[29]) else $error("ma");
    chk_rdata_idle: assert property (!hit |=> cfg_rdata_o == 32'h0) else $error("rd");
    cov_serr: cover property (!serr_oe_n_o);
    cov_master: cover property ($rose(master_en_o));
    cov_abort: cover property (events_i.master_abort_rx ##1 hit);
endmodule // bpcs_chk
bind bpcs_regs bpcs_chk u_chk (.*);
`default_nettype wire

// file: bench/bpcs_agent.sv
// primary bus agent turning event requests into status pulses
`timescale 1ns/1ns
`default_nettype none
module bpcs_agent (
    input wire logic clock_i, // clock
    input wire logic [6:0] ev_i, // requested events, msb first
    output bpcs_pkg::bpcs_event_type events_o // pulses to the bridge
);
    always_ff @(posedge clock_i) events_o <= bpcs_pkg::bpcs_event_type'(ev_i);
endmodule // bpcs_agent
`default_nettype wire

// file: bench/bridge_primary_command_status_tb_top.sv
// bench for the primary command and status registers
`timescale 1ns/1ns
`default_nettype none
module bridge_primary_command_status_tb_top;
    logic clock_i = 0, arst_n_i = 0, cfg_write_i = 0, cfg_read_i = 0, serr_request_i = 0, io_write_i = 0;
    logic [7:0] cfg_addr_i = 8'h04;
    logic [3:0] cfg_be_i = 4'h0;
    logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o;
    logic [9:0] io_addr_i = 10'h0;
    logic [6:0] ev = 7'h00;
    logic serr_n_o, serr_oe_n_o, parity_resp_en_o, mem_fwd_en_o, io_fwd_en_o, master_en_o, secondary_resp_en_o;
    logic vga_fwd_o;
    bpcs_pkg::bpcs_event_type events_i;
    int num_errors = 0, samples_checked = 0;
    logic [9:0] va [4] = '{10'h3c6, 10'h3c8, 10'h3c9, 10'h3c7};
    bpcs_agent agent (.clock_i(clock_i), .ev_i(ev), .events_o(events_i));
    bpcs_regs uut (.*);
    initial forever #5 clock_i = ~clock_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        num_errors += int'(seen !== exp);
        if (seen !== exp) $display("BAD %0t seen %h expected %h", $time, seen, exp);
    endtask
    task automatic write(input logic [3:0] b, input logic [31:0] d);
        @(negedge clock_i) {cfg_write_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = {1'b1, 8'h04, b, d};
        @(negedge clock_i) cfg_write_i = 0;
    endtask
    task automatic read(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clock_i) {cfg_read_i, cfg_addr_i} = {1'b1, a};
        @(negedge clock_i) cfg_read_i = 0;
        check(cfg_rdata_o, exp);
    endtask
    task automatic pulse(input logic [6:0] e);
        @(negedge clock_i) ev = e;
        @(negedge clock_i) ev = 0;
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge clock_i);
        arst_n_i = 1;
        read(8'h04, 32'h0210_0000);
        write(4'h3, 32'hffff_ffff);
        read(8'h04, 32'h0210_0367);
        check(32'({parity_resp_en_o, mem_fwd_en_o, io_fwd_en_o, master_en_o, secondary_resp_en_o}), 32'h1f);
        io_write_i = 1;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clock_i) io_addr_i = va[i];
            #1 check(32'(vga_fwd_o), 32'(i < 3));
        end
        serr_request_i = 1;
        #1 check(32'(serr_oe_n_o), 32'h0);
        pulse(7'h7f);
        read(8'h04, 32'hfb10_0367);
        write(4'hc, 32'h2000_0000);
        read(8'h04, 32'hdb10_0367);
        write(4'hf, 32'hffff_0000);
        check(32'({serr_oe_n_o, master_en_o, secondary_resp_en_o}), 32'h4);
        pulse(7'h7f);
        read(8'h04, 32'hba10_0000);
        check(32'(serr_n_o), 32'h0);
        io_addr_i = 10'h3c6;
        #1 check(32'(vga_fwd_o), 32'h0);
        write(4'hf, 32'hffff_0040);
        pulse(7'h02);
        pulse(7'h01);
        read(8'h04, 32'h0210_0040);
        // the clear write is taken at the very edge that sees the abort event
        fork
            pulse(7'h10);
            begin
                @(negedge clock_i);
                write(4'hc, 32'h2000_0000);
            end
        join
        read(8'h04, 32'h2210_0040);
        read(8'h08, 32'h0);
        final_report;
    end
    initial
    begin
        #20000;
        num_errors++;
        final_report;
    end
endmodule // bridge_primary_command_status_tb_top
`default_nettype wire
